/* File: logic/ebm_params.svh */
// Constants for the energy buffer mode control block.
// Assumes inclusion by bare name from logic/.
`ifndef EBM_PARAMS_SVH
`define EBM_PARAMS_SVH
// Register indices; byte address is four times the index
`define EBM_IDX_STATUS 7'h00
`define EBM_IDX_CMD    7'h08
`define EBM_IDX_OUTSET 7'h09
`define EBM_IDX_SETTING_THREE   7'h11
// Command fields
`define EBM_CMD_EOD   0
`define EBM_CMD_ECM   1
`define EBM_CMD_ACT   2
`define EBM_CMD_RSTPF 3
`define EBM_CMD_PROF_LO 4
`define EBM_CMD_PROF_HI 7
`define EBM_SETTING_THREE_AUTO 7
// Output setting fields: [3:0] setpoint code, [6:4] charge current code
`define EBM_VSET_HI 3
`define EBM_ICH_LO  4
`define EBM_ICH_HI  6
// Power-on values: 3.0 V setpoint, 8 mA charge current, profile 1
`define EBM_VSET_3V0  4'h6
`define EBM_ICH_8MA   3'h2
`define EBM_PROF_ONE  4'h1
`define EBM_SETTING_THREE_RST  8'h00
// Timing
`define EBM_CLK_MHZ   20
`define EBM_NL_TIME_US 100
`define EBM_NL_CYC    (`EBM_NL_TIME_US * `EBM_CLK_MHZ)
`endif

/* File: logic/ebm_pkg.sv */
// Types for the energy buffer mode control block.
// Assumes a Wishbone classic master with 32-bit data.
package ebm_pkg;
  typedef enum logic [3:0] {
    EBM_STBY   = 4'b0001,
    EBM_CHARGE = 4'b0010,
    EBM_IDLE   = 4'b0100,
    EBM_ACTIVE = 4'b1000
  } ebm_state_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } ebm_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } ebm_wb_rsp_s;

  // Indications from the analog converters
  typedef struct packed {
    logic charge_done;
    logic cap_below;
    logic cap_depleted;
    logic out_in_reg;
    logic no_load;
  } ebm_ana_s;

  typedef struct packed {
    logic [3:0] vset;
    logic [2:0] ich;
    logic [5:0] prof;
    logic       opt_active;
  } ebm_cfg_s;
endpackage

/* File: logic/ebm_mode_ctrl.sv */
// Operating-mode state machine of a battery energy buffer.
// Assumes a Wishbone classic master, asynchronous START, and
// analog indications synchronous to clk_i.
//
// Summary of operation
// - Command bit 0 starts on-demand: charge capacitor, then enable output.
// - On-demand charges the capacitor before the output stage is enabled.
// - On-demand raises ready when the output can deliver full power.
// - On-demand ends only when on-demand and force-active bits are clear.
// - Command bit 1 starts continuous: charge capacitor, then idle.
// - Continuous idles the charger once the charge target is reached.
// - Continuous recharges whenever capacitor voltage drops below target.
// - Force-active in continuous enables the output immediately.
// - Continuous recharges the capacitor after an active pulse.
// - Active and recharge may alternate repeatedly in continuous.
// - Continuous raises ready each time the capacitor reaches target.
// - Continuous ends only when continuous and force-active bits are clear.
// - With no mode selected the block rests in standby.
// - Command bit 3 clears the optimizer result of the current profile.
// - Setting-three bit 7 enables auto mode; default follows the variant.
// - On the variant without auto mode that bit stays zero.
// - In auto mode a START rising edge sets the on-demand request.
// - In auto mode charging completion enters active; ready follows regulation.
// - After a short START pulse, active ends after sustained no-load.
// - After a long START pulse, active ends when START falls.
// - START falling during charge makes the cycle a short-pulse one.
// - Auto variant powers up in auto mode, 3.0 V, 8 mA, profile 1.
// - Mode changes are accepted at any time without visiting standby.
// - Status bit 0 mirrors the ready output.
// - On-demand ready falls on on-demand clear or capacitor depletion.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "ebm_params.svh"

module ebm_mode_ctrl #(
  parameter bit AUTO_VARIANT = 1'b1
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire ebm_pkg::ebm_wb_req_s wb_req_i,
  output var  ebm_pkg::ebm_wb_rsp_s wb_rsp_o,
  input  wire logic                 start_i,
  input  wire ebm_pkg::ebm_ana_s    ana_i,
  output logic                      charge_en_o,
  output logic                      out_en_o,
  output logic                      rdy_o,
  output logic                      opt_clear_o,
  output var  ebm_pkg::ebm_cfg_s    cfg_o
);
  import ebm_pkg::*;

  // ==========================================================
  // Register bus decode
  function automatic logic hit(input logic [31:0] a,
                               input logic [6:0]  idx);
    hit = (a[31:2] == {23'h0, idx});
  endfunction

  logic        ack_r;
  logic [7:0]  rd_r;
  wire  logic  req    = wb_req_i.cyc & wb_req_i.stb & ~ack_r;
  wire  logic  wr_en  = req & wb_req_i.we & wb_req_i.sel[0];
  wire  logic  rd_en  = req & ~wb_req_i.we;
  wire  logic  hit_st = hit(wb_req_i.adr, `EBM_IDX_STATUS);
  wire  logic  hit_cm = hit(wb_req_i.adr, `EBM_IDX_CMD);
  wire  logic  hit_os = hit(wb_req_i.adr, `EBM_IDX_OUTSET);
  wire  logic  hit_s3 = hit(wb_req_i.adr, `EBM_IDX_SETTING_THREE);
  wire  logic  wr_cm  = wr_en & hit_cm;
  wire  logic  wr_os  = wr_en & hit_os;
  wire  logic  wr_s3  = wr_en & hit_s3;
  wire  logic [7:0] wd = wb_req_i.dat[7:0];

  // ==========================================================
  // Configuration registers
  logic       eod_r;
  logic       ecm_r;
  logic       act_r;
  logic [3:0] prof_r;
  logic [7:0] setting_three_r;
  logic [7:0] outset_r;
  logic       opt_clr_r;

  wire logic automode = setting_three_r[`EBM_SETTING_THREE_AUTO];
  wire logic [7:0] setting_three_rst = AUTO_VARIANT ?
    (`EBM_SETTING_THREE_RST | (8'h01 << `EBM_SETTING_THREE_AUTO)) : `EBM_SETTING_THREE_RST;
  // Auto bit cannot be written to one on the non-auto variant
  wire logic [7:0] setting_three_wd = AUTO_VARIANT ? wd :
    (wd & ~(8'h01 << `EBM_SETTING_THREE_AUTO));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setting_three_r   <= setting_three_rst;
      outset_r <= {1'b0, `EBM_ICH_8MA, `EBM_VSET_3V0};
      prof_r   <= `EBM_PROF_ONE;
    end else begin
      if (wr_s3) setting_three_r <= setting_three_wd;
      if (wr_os) outset_r <= wd;
      if (wr_cm) prof_r <= wd[`EBM_CMD_PROF_HI:`EBM_CMD_PROF_LO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) opt_clr_r <= 1'b0;
    else opt_clr_r <= wr_cm & wd[`EBM_CMD_RSTPF];
  end

  assign cfg_o.vset       = outset_r[`EBM_VSET_HI:0];
  assign cfg_o.ich        = outset_r[`EBM_ICH_HI:`EBM_ICH_LO];
  assign cfg_o.prof       = {2'b00, prof_r};
  assign cfg_o.opt_active = (prof_r != 4'h0);
  assign opt_clear_o      = opt_clr_r;

  // ==========================================================
  // START synchroniser and edge detection
  logic start_m_r;
  logic start_s_r;
  logic start_d_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_m_r <= 1'b0;
      start_s_r <= 1'b0;
      start_d_r <= 1'b0;
    end else begin
      start_m_r <= start_i;
      start_s_r <= start_m_r;
      start_d_r <= start_s_r;
    end
  end

  wire logic start_rise = start_s_r & ~start_d_r;
  wire logic auto_set   = automode & start_rise;

  // ==========================================================
  // Mode state machine
  ebm_state_e st_r;
  ebm_state_e st_nxt;
  logic       auto_cyc_r;
  logic       long_r;
  logic [11:0] nl_cnt_r;
  logic       rdy_r;

  wire logic cont    = ecm_r;
  wire logic run_any = eod_r | ecm_r | act_r;
  wire logic in_act  = (st_r == EBM_ACTIVE);
  wire logic nl_done = (nl_cnt_r == 12'(`EBM_NL_CYC));
  // Auto cycle end: long pulse on START fall, short on no-load time
  wire logic auto_end = in_act & auto_cyc_r & ~cont &
    (long_r ? ~start_s_r : nl_done);

  // The START edge wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eod_r <= 1'b0;
      ecm_r <= 1'b0;
      act_r <= 1'b0;
    end else begin
      if (auto_set) eod_r <= 1'b1;
      else if (wr_cm) eod_r <= wd[`EBM_CMD_EOD];
      else if (auto_end) eod_r <= 1'b0;
      if (wr_cm) begin
        ecm_r <= wd[`EBM_CMD_ECM];
        act_r <= wd[`EBM_CMD_ACT];
      end
    end
  end

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      EBM_STBY: begin
        if (run_any) st_nxt = EBM_CHARGE;
      end
      EBM_CHARGE: begin
        if (!run_any) st_nxt = EBM_STBY;
        else if (cont && act_r) st_nxt = EBM_ACTIVE;
        else if (ana_i.charge_done)
          st_nxt = cont ? EBM_IDLE : EBM_ACTIVE;
      end
      EBM_IDLE: begin
        if (!run_any) st_nxt = EBM_STBY;
        else if (act_r || !cont) st_nxt = EBM_ACTIVE;
        else if (ana_i.cap_below) st_nxt = EBM_CHARGE;
      end
      EBM_ACTIVE: begin
        if (!run_any) st_nxt = EBM_STBY;
        else if (cont && !act_r) st_nxt = EBM_CHARGE;
      end
      default: st_nxt = EBM_STBY;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) st_r <= EBM_STBY;
    else st_r <= st_nxt;
  end

  // A cycle counts as long only if START is still high on reaching active
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_cyc_r <= 1'b0;
      long_r     <= 1'b0;
    end else begin
      if (auto_set && st_r == EBM_STBY) auto_cyc_r <= 1'b1;
      else if (st_nxt == EBM_STBY) auto_cyc_r <= 1'b0;
      if (st_r == EBM_CHARGE && st_nxt == EBM_ACTIVE)
        long_r <= start_s_r;
      else if (!in_act) long_r <= 1'b0;
    end
  end

  // No-load timer; any load resets it
  always_ff @(posedge clk_i) begin
    if (rst_i) nl_cnt_r <= 12'h000;
    else if (!in_act || !ana_i.no_load) nl_cnt_r <= 12'h000;
    else if (!nl_done) nl_cnt_r <= nl_cnt_r + 12'h001;
  end

  // ==========================================================
  // Ready output
  wire logic rdy_od = in_act & eod_r & ana_i.out_in_reg &
    ~ana_i.cap_depleted;
  wire logic rdy_cm = (st_r == EBM_IDLE) |
    (in_act & ana_i.out_in_reg);
  wire logic rdy_nxt = cont ? rdy_cm : rdy_od;

  always_ff @(posedge clk_i) begin
    if (rst_i) rdy_r <= 1'b0;
    else rdy_r <= rdy_nxt;
  end

  assign rdy_o       = rdy_r;
  assign charge_en_o = (st_r == EBM_CHARGE);
  assign out_en_o    = in_act;

  // ==========================================================
  // Bus answer; command register is write-only and reads zero
  wire logic [7:0] rd_mux =
    hit_st ? {7'h00, rdy_r} :
    hit_os ? outset_r :
    hit_s3 ? setting_three_r : 8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rd_r  <= 8'h00;
    end else begin
      ack_r <= req;
      if (rd_en) rd_r <= rd_mux;
    end
  end

  assign wb_rsp_o.ack = ack_r;
  assign wb_rsp_o.dat = {24'h000000, rd_r};

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  status_rdy_a: assert property (
    (rd_en && hit_st) |=> (wb_rsp_o.ack && wb_rsp_o.dat[0] == $past(rdy_o)))
    else $error("status ready bit differs from ready pin");

  od_start_a: assert property (
    (st_r == EBM_STBY && eod_r) |=> charge_en_o)
    else $error("on-demand did not start charging");

  charge_first_a: assert property (
    ($rose(out_en_o) && !ecm_r) |->
      ($past(charge_en_o) || $past(st_r == EBM_IDLE)))
    else $error("output enabled without a charge phase");

  od_rdy_drop_a: assert property (
    (in_act && !ecm_r && (!eod_r || ana_i.cap_depleted)) |=> !rdy_o)
    else $error("on-demand ready did not fall");

  cont_idle_a: assert property (
    (charge_en_o && ecm_r && !act_r && ana_i.charge_done) |=>
      (st_r == EBM_IDLE && !charge_en_o))
    else $error("continuous did not idle at target");

  refresh_a: assert property (
    (st_r == EBM_IDLE && ecm_r && !act_r && ana_i.cap_below) |=>
      charge_en_o)
    else $error("continuous refresh missing");

  force_act_a: assert property (
    (st_r == EBM_IDLE && act_r) |=> out_en_o)
    else $error("force active not immediate");

  standby_a: assert property (
    (!run_any && !auto_set && !wr_cm) |=> ##1 (st_r == EBM_STBY))
    else $error("not in standby with no mode");

  auto_lock_a: assert property (
    !AUTO_VARIANT |-> !automode)
    else $error("auto bit set on non-auto variant");

  start_edge_a: assert property (
    $rose(start_s_r) && automode |=> eod_r)
    else $error("start edge did not request a cycle");

  opt_clear_a: assert property (
    (wr_cm && wd[`EBM_CMD_RSTPF]) |=> opt_clear_o ##1 !opt_clear_o)
    else $error("optimizer clear pulse wrong");

  long_end_a: assert property (
    (in_act && auto_cyc_r && long_r && !ecm_r && !start_s_r &&
     !auto_set && !wr_cm) |=> !eod_r)
    else $error("long pulse did not end active");

  od_ready_a: assert property (
    (in_act && !ecm_r && eod_r && ana_i.out_in_reg && !ana_i.cap_depleted) |=> rdy_o)
    else $error("on-demand ready did not rise");

  cont_ready_a: assert property (
    (st_r == EBM_IDLE && ecm_r) |=> rdy_o)
    else $error("continuous ready missing at target");

  auto_active_a: assert property (
    (st_r == EBM_CHARGE && eod_r && !ecm_r && !act_r && ana_i.charge_done) |=> out_en_o)
    else $error("charge end did not enter active");

  short_end_a: assert property (
    (in_act && auto_cyc_r && !long_r && !ecm_r && nl_done && !auto_set && !wr_cm) |=> !eod_r)
    else $error("short pulse did not end on no-load");

  short_fall_a: assert property (
    (st_r == EBM_CHARGE && st_nxt == EBM_ACTIVE && !start_s_r) |=> !long_r)
    else $error("start low in charge not taken as short");

  mode_end_a: assert property (
    (!eod_r && !ecm_r && !act_r) |=> (!charge_en_o && !out_en_o))
    else $error("cleared mode bits did not reach standby");

  mode_switch_a: assert property (
    (in_act && (eod_r || act_r) && !(ecm_r && !act_r)) |=> out_en_o)
    else $error("mode change left the active state");
endmodule

`default_nettype wire

/* File: tb/ebm_mcu_model.sv */
// Microcontroller model that drives the START pin of the mode controller.
// Assumes go_short_i and go_long_i are one-cycle requests from the bench.
`timescale 1ns/1ps
`default_nettype none

module ebm_mcu_model #(
  parameter int HOLD_CYC = 220,
  parameter int LOAD_CYC = 100
) (
  input  wire logic clk_i,
  input  wire logic go_short_i,
  input  wire logic go_long_i,
  input  wire logic rdy_i,
  output logic      start_o
);
  int   cnt_r;
  logic long_r;

  initial begin
    start_o = 1'b0;
    cnt_r   = 0;
    long_r  = 1'b0;
  end

  // ==========================================================
  // START pulse shaping
  // A long pulse counts down only in cycles where ready is high
  always @(posedge clk_i) begin
    if (go_short_i || go_long_i) begin
      start_o <= 1'b1;
      long_r  <= go_long_i;
      cnt_r   <= go_short_i ? HOLD_CYC : LOAD_CYC;
    end else if (start_o && (!long_r || rdy_i)) begin
      if (cnt_r <= 1) begin
        start_o <= 1'b0;
      end
      cnt_r <= cnt_r - 1;
    end
  end
endmodule
`default_nettype wire

/* File: tb/ebm_mode_ctrl_test.sv */
// Self-checking bench for the energy buffer mode control block.
// Assumes the auto-start variant and analog indications driven here.
`timescale 1ns/1ps
`default_nettype none
`include "ebm_params.svh"

module ebm_mode_ctrl_test;
  import ebm_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  ebm_wb_req_s wb_req = '0;
  ebm_wb_rsp_s wb_rsp;
  ebm_ana_s    ana = '0;
  ebm_cfg_s    cfg;
  logic        start, charge_en, out_en, rdy, opt_clear;
  logic        go_short = 1'b0;
  logic        go_long = 1'b0;
  int          errors = 0;
  int          n_checks = 0;
  int          n_clr = 0;
  logic [7:0]  rd;
  logic [7:0]  rd_b;
  ebm_wb_rsp_s wb_rsp_b;
  logic        charge_en_b;

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (opt_clear === 1'b1) n_clr++;

  ebm_mode_ctrl #(.AUTO_VARIANT(1'b1)) ebm_mode_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(wb_req), .wb_rsp_o(wb_rsp), .start_i(start), .ana_i(ana), .charge_en_o(charge_en),
    .out_en_o(out_en), .rdy_o(rdy), .opt_clear_o(opt_clear), .cfg_o(cfg));
  ebm_mcu_model ebm_mcu_model_inst (.clk_i(clk_i), .go_short_i(go_short), .go_long_i(go_long),
    .rdy_i(rdy), .start_o(start));
  // Second copy without auto mode shares the bus and pins
  ebm_mode_ctrl #(.AUTO_VARIANT(1'b0)) ebm_mode_ctrl_inst_b (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(wb_req), .wb_rsp_o(wb_rsp_b), .start_i(start), .ana_i(ana), .charge_en_o(charge_en_b),
    .out_en_o(), .rdy_o(), .opt_clear_o(), .cfg_o());

  // ==========================================================
  // Shared tasks
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [6:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    wb_req <= '{cyc:1'b1, stb:1'b1, we:we, sel:4'hf, adr:{23'h0, idx, 2'b00}, dat:{24'h0, wd}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 20);
    if (wb_rsp.ack !== 1'b1) errors++;
    rd = wb_rsp.dat[7:0];
    rd_b = wb_rsp_b.dat[7:0];
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input string name, input logic [6:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    check(name, exp, rd);
  endtask

  // Outputs packed as {charge_en, out_en, rdy}
  task automatic wait_out(input string name, input logic [7:0] exp, input int n);
    for (int i = 0; i < n && {5'h0, charge_en, out_en, rdy} !== exp; i++) @(posedge clk_i);
    check(name, exp, {5'h0, charge_en, out_en, rdy});
  endtask

  task automatic stop_test();
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rdchk("setting_three", `EBM_IDX_SETTING_THREE, 8'h80);
    check("setting_three_b", 8'h00, rd_b);
    rdchk("outset", `EBM_IDX_OUTSET, {1'b0, `EBM_ICH_8MA, `EBM_VSET_3V0});
    check("prof", 8'h01, {2'b00, cfg.prof});
    check("cfg", {1'b1, `EBM_ICH_8MA, `EBM_VSET_3V0}, {cfg.opt_active, cfg.ich, cfg.vset});
    rdchk("unmapped", 7'h30, 8'h00);
    rdchk("status", `EBM_IDX_STATUS, 8'h00);
  endtask

  task automatic t_lock();
    wb(1'b1, `EBM_IDX_SETTING_THREE, 8'h80);
    rdchk("setting_three_keep", `EBM_IDX_SETTING_THREE, 8'h80);
    check("setting_three_lock", 8'h00, rd_b);
  endtask

  task automatic t_ondemand();
    wb(1'b1, `EBM_IDX_CMD, 8'h11);
    wait_out("od_charge", 8'h04, 5);
    ana.charge_done <= 1'b1;
    wait_out("od_active", 8'h02, 5);
    ana.out_in_reg <= 1'b1;
    wait_out("od_rdy", 8'h03, 5);
    rdchk("status", `EBM_IDX_STATUS, 8'h01);
    ana.cap_depleted <= 1'b1;
    wait_out("od_depl", 8'h02, 5);
    ana.cap_depleted <= 1'b0;
    wb(1'b1, `EBM_IDX_CMD, 8'h10);
    wait_out("od_end", 8'h00, 5);
  endtask

  task automatic t_continuous();
    ana.charge_done <= 1'b0;
    wb(1'b1, `EBM_IDX_CMD, 8'h12);
    wait_out("cm_charge", 8'h04, 5);
    ana.charge_done <= 1'b1;
    wait_out("cm_idle", 8'h01, 5);
    ana.charge_done <= 1'b0;
    ana.cap_below <= 1'b1;
    wait_out("cm_refresh", 8'h04, 5);
    ana.cap_below <= 1'b0;
    ana.charge_done <= 1'b1;
    wait_out("cm_idle2", 8'h01, 5);
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, `EBM_IDX_CMD, 8'h16);
      wait_out("cm_active", 8'h03, 5);
      ana.charge_done <= 1'b0;
      wb(1'b1, `EBM_IDX_CMD, 8'h12);
      wait_out("cm_recharge", 8'h04, 5);
      ana.charge_done <= 1'b1;
      wait_out("cm_idle3", 8'h01, 5);
    end
    wb(1'b1, `EBM_IDX_CMD, 8'h16);
    wb(1'b1, `EBM_IDX_CMD, 8'h11);
    wait_out("cm_to_od", 8'h03, 5);
    wb(1'b1, `EBM_IDX_CMD, 8'h10);
    wait_out("cm_end", 8'h00, 5);
    wb(1'b1, `EBM_IDX_CMD, 8'h13);
    wait_out("both_set", 8'h01, 8);
    wb(1'b1, `EBM_IDX_CMD, 8'h10);
    wait_out("both_end", 8'h00, 5);
  endtask

  task automatic t_rstpf();
    int c0;
    c0 = n_clr;
    wb(1'b1, `EBM_IDX_CMD, 8'h18);
    wb(1'b1, `EBM_IDX_CMD, 8'h10);
    check("opt_clear", 8'h01, 8'(n_clr - c0));
  endtask

  task automatic t_auto(input logic long_p);
    ana.charge_done <= 1'b0;
    go_short <= !long_p;
    go_long <= long_p;
    @(posedge clk_i);
    go_short <= 1'b0;
    go_long <= 1'b0;
    wait_out("au_charge", 8'h04, 10);
    check("b_no_auto", 8'h00, {7'h00, charge_en_b});
    for (int i = 0; i < 300 && !long_p && start !== 1'b0; i++) @(posedge clk_i);
    // The START fall needs the synchroniser's latency before charge ends
    repeat (4) @(posedge clk_i);
    ana.charge_done <= 1'b1;
    ana.no_load <= !long_p;
    wait_out("au_active", 8'h03, 5);
    repeat (long_p ? 50 : 1500) @(posedge clk_i);
    check("au_hold", 8'h03, {5'h0, charge_en, out_en, rdy});
    wait_out("au_end", 8'h00, 700);
    ana.no_load <= 1'b0;
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_lock();
    t_ondemand();
    t_continuous();
    t_rstpf();
    t_auto(1'b0);
    t_auto(1'b1);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
